/* File: arseq_top.v */
// Auto-recloser sequencer with APB register file, events and counters
`include "arseq_regs.vh"
module arseq_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [4:0] reclose_request_in,
  input wire recloser_enable_input,
  input wire recloser_manual_clear,
  input wire recloser_lock_input,
  input wire critical_lockout_request,
  input wire breaker_open_status,
  input wire breaker_closed_status,
  input wire manual_open_cmd,
  input wire manual_close_cmd,
  input wire object_fail,
  output reg object_open_cmd,
  output reg object_close_cmd,
  output wire recloser_on,
  output wire recloser_running,
  output wire recloser_locked,
  output wire recloser_ready,
  output wire dead_time_on,
  output wire reclaim_time_on,
  output wire arcing_time_on,
  output wire final_trip_on,
  output wire [4:0] request_active,
  output wire [4:0] shot_running,
  output wire event_valid,
  output wire [7:0] event_code,
  output wire [31:0] event_stamp,
  input wire event_ready
);
localparam S_READY = 4'd0, S_OPEN = 4'd1, S_DEAD = 4'd2, S_CLOSE = 4'd3;
localparam S_RECLAIM = 4'd4, S_GRECL = 4'd5, S_FTRIP = 4'd6;
localparam S_LOCK = 4'd7, S_HALT = 4'd8, S_OFF = 4'd9;
////////////////////////////////////////////////////////////////////////////
// Input synchronisers: three flops, change accepted when last two agree
wire [13:0] raw_in = {object_fail, manual_close_cmd, manual_open_cmd,
  breaker_closed_status, breaker_open_status, critical_lockout_request,
  recloser_lock_input, recloser_manual_clear, recloser_enable_input,
  reclose_request_in};
reg [13:0] s1_r, s2_r, s3_r, in_r;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    s1_r <= 14'h0000;
    s2_r <= 14'h0000;
    s3_r <= 14'h0000;
    in_r <= 14'h0000;
  end else begin
    s1_r <= raw_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
    in_r <= (s2_r & s3_r) | (in_r & (s2_r | s3_r));
  end
end
reg [13:0] in_d_r;
wire [4:0] req = in_r[4:0];
wire en_in = in_r[5];
wire mclr = in_r[6];
wire lock_in = in_r[7];
wire crit = in_r[8];
wire brk_open = in_r[9];
wire brk_closed = in_r[10];
wire man_rise = (in_r[11] & ~in_d_r[11]) | (in_r[12] & ~in_d_r[12]);
wire man_close = in_r[12] & ~in_d_r[12];
wire fail = in_r[13];
wire any_req = |req;
////////////////////////////////////////////////////////////////////////////
// Millisecond tick
reg [15:0] div_r;
reg [31:0] ms_r;
wire tick = (div_r == `ARSEQ_TICK_CYC - 1);
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    div_r <= 16'h0000;
    ms_r <= 32'h0000_0000;
  end else begin
    div_r <= tick ? 16'h0000 : div_r + 16'h0001;
    if (tick)
      ms_r <= ms_r + 32'h0000_0001;
  end
end
////////////////////////////////////////////////////////////////////////////
// Settings (live: changes act immediately)
reg [31:0] ctrl_r, dead_r, reclaim_r, action_r, grcl_r, evten_r;
wire use_in = ctrl_r[`ARSEQ_CTRL_USE_IN];
wire on = ctrl_r[`ARSEQ_CTRL_ENABLE] & (~use_in | en_in);
wire [2:0] nshots = ctrl_r[`ARSEQ_CTRL_SHOTS_HI:`ARSEQ_CTRL_SHOTS_LO];
reg [3:0] st_r;
reg [2:0] shot_r;
reg [2:0] prio_r;
// Per-shot timer fields: reclaim and action 16 bits each, even shot low half; dead time 8 bits per shot
function [15:0] pick16;
  input [31:0] w;
  input [2:0] s;
  begin
    pick16 = s[0] ? w[31:16] : w[15:0];
  end
endfunction
// One mode bit per shot: 1 discrimination, 0 arcing, so never both
wire disc_mode = ctrl_r[`ARSEQ_CTRL_MODE_LO + shot_r];
wire [15:0] dead_set = dead_r[8*shot_r[1:0] +: 8] == 8'h00 ? 16'h0000 :
  {8'h00, dead_r[8*shot_r[1:0] +: 8]};
wire [15:0] recl_set = pick16(reclaim_r, shot_r);
wire [15:0] act_set = pick16(action_r, shot_r);
wire [15:0] grcl_set = grcl_r[15:0];
////////////////////////////////////////////////////////////////////////////
// Sequencer
reg [15:0] tmr_r, act_r;
reg succ_r;
wire [2:0] top_req = req[0] ? 3'd0 : req[1] ? 3'd1 : req[2] ? 3'd2 :
  req[3] ? 3'd3 : 3'd4;
wire more_shots = ({1'b0, shot_r} + 4'd1) < {1'b0, nshots};
wire act_run = (st_r == S_RECLAIM) & ~disc_mode & any_req &
  (act_set != 16'h0000);
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    st_r <= S_OFF;
    shot_r <= 3'd0;
    prio_r <= 3'd0;
    tmr_r <= 16'h0000;
    act_r <= 16'h0000;
    succ_r <= 1'b0;
    object_open_cmd <= 1'b0;
    object_close_cmd <= 1'b0;
    in_d_r <= 14'h0000;
  end else begin
    in_d_r <= in_r;
    if (tick && tmr_r != 16'hFFFF)
      tmr_r <= tmr_r + 16'h0001;
    if (crit) begin
      st_r <= S_LOCK;
      object_open_cmd <= 1'b0;
      object_close_cmd <= 1'b0;
    end else if (lock_in && st_r != S_HALT) begin
      st_r <= S_LOCK;
      object_close_cmd <= 1'b0;
    end else if (man_close && st_r == S_DEAD) begin
      st_r <= S_GRECL;
      succ_r <= 1'b0;
      tmr_r <= 16'h0000;
      object_close_cmd <= 1'b0;
    end else if (man_rise && st_r != S_READY && st_r != S_LOCK &&
                 st_r != S_OFF && st_r != S_HALT) begin
      st_r <= S_READY;
      object_open_cmd <= 1'b0;
      object_close_cmd <= 1'b0;
    end else if (fail && (st_r == S_OPEN || st_r == S_CLOSE)) begin
      st_r <= S_LOCK;
      object_open_cmd <= 1'b0;
      object_close_cmd <= 1'b0;
    end else begin
      case (st_r)
        S_OFF: if (on) st_r <= S_READY;
        S_READY: begin
          if (!on) st_r <= S_OFF;
          else if (any_req && nshots != 3'd0) begin
            prio_r <= top_req;
            shot_r <= 3'd0;
            object_open_cmd <= 1'b1;
            st_r <= S_OPEN;
          end
        end
        S_OPEN: if (brk_open) begin
          object_open_cmd <= 1'b0;
          tmr_r <= 16'h0000;
          st_r <= S_DEAD;
        end
        S_DEAD: if (dead_set == 16'h0000 || tmr_r >= dead_set) begin
          object_close_cmd <= 1'b1;
          st_r <= S_CLOSE;
        end
        S_CLOSE: if (brk_closed) begin
          object_close_cmd <= 1'b0;
          tmr_r <= 16'h0000;
          act_r <= 16'h0000;
          st_r <= S_RECLAIM;
        end
        S_RECLAIM: begin
          if (act_run && tick)
            act_r <= act_r + 16'h0001;
          if (disc_mode && act_set != 16'h0000 && tmr_r < act_set &&
              any_req) begin
            st_r <= S_HALT;
          end else if ((!disc_mode && act_set != 16'h0000) ?
                       (any_req && act_r >= act_set) :
                       (any_req && (disc_mode || act_set == 16'h0000))) begin
            // Fault persists: next shot or final trip
            if (more_shots) begin
              shot_r <= shot_r + 3'd1;
              object_open_cmd <= 1'b1;
              st_r <= S_OPEN;
            end else begin
              object_open_cmd <= 1'b1;
              st_r <= S_FTRIP;
            end
          end else if (recl_set == 16'h0000 || tmr_r >= recl_set) begin
            succ_r <= 1'b1;
            tmr_r <= 16'h0000;
            st_r <= (ctrl_r[`ARSEQ_CTRL_USE_GRCL] && grcl_set != 16'h0000)
              ? S_GRECL : S_READY;
          end
        end
        S_GRECL: begin
          if (!succ_r || any_req) begin
            // Fault in general reclaim, or after manual close
            object_open_cmd <= any_req;
            st_r <= any_req ? S_FTRIP : S_LOCK;
          end else if (tmr_r >= grcl_set)
            st_r <= S_READY;
        end
        S_FTRIP: if (brk_open) begin
          object_open_cmd <= 1'b0;
          st_r <= S_LOCK;
        end
        S_LOCK: if (mclr && !lock_in) st_r <= S_READY;
        S_HALT: if (mclr && brk_closed) st_r <= S_READY;
        default: st_r <= S_OFF;
      endcase
    end
  end
end
////////////////////////////////////////////////////////////////////////////
// Status indications
assign recloser_on = on;
assign recloser_ready = (st_r == S_READY);
assign recloser_locked = (st_r == S_LOCK) | (st_r == S_HALT);
assign dead_time_on = (st_r == S_DEAD);
assign reclaim_time_on = (st_r == S_RECLAIM) | (st_r == S_GRECL);
assign arcing_time_on = act_run;
assign final_trip_on = (st_r == S_FTRIP);
wire seq = (st_r >= S_OPEN) & (st_r <= S_RECLAIM);
assign recloser_running = seq;
assign request_active = seq ? (5'h01 << prio_r) : 5'h00;
assign shot_running = seq ? (5'h01 << shot_r) : 5'h00;
////////////////////////////////////////////////////////////////////////////
// Events: input changes, commands and status, stamped in ms
wire [23:0] ev_vec = {object_open_cmd, object_close_cmd, recloser_ready,
  recloser_locked, dead_time_on, reclaim_time_on, arcing_time_on,
  final_trip_on, recloser_running, on, in_r};
reg [23:0] ev_d_r, ev_pend_r;
reg [4:0] ev_idx;
reg ev_hit;
integer k;
always @* begin
  ev_idx = 5'd0;
  ev_hit = 1'b0;
  for (k = 23; k >= 0; k = k - 1)
    if (ev_pend_r[k]) begin
      ev_idx = k[4:0];
      ev_hit = 1'b1;
    end
end
reg ev_v_r;
reg [7:0] ev_c_r;
reg [31:0] ev_s_r;
wire ev_load = ev_hit & (~ev_v_r | event_ready);
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ev_d_r <= 24'h000000;
    ev_pend_r <= 24'h000000;
    ev_v_r <= 1'b0;
    ev_c_r <= 8'h00;
    ev_s_r <= 32'h0000_0000;
  end else begin
    ev_d_r <= ev_vec;
    // New change wins over the clear of the one just taken
    ev_pend_r <= (ev_pend_r & ~(ev_load ? (24'h000001 << ev_idx) :
      24'h000000)) | ((ev_vec ^ ev_d_r) & evten_r[23:0]);
    if (ev_load) begin
      ev_v_r <= 1'b1;
      ev_c_r <= {2'b00, ev_vec[ev_idx], ev_idx};
      ev_s_r <= ms_r;
    end else if (event_ready)
      ev_v_r <= 1'b0;
  end
end
assign event_valid = ev_v_r;
assign event_code = ev_c_r;
assign event_stamp = ev_s_r;
////////////////////////////////////////////////////////////////////////////
// Counters: 0-4 per request sequence start, 5 any reclaim exit while succ_r is set, 6 final trip, 7 lock,
// 8 halt, 9 manual reset
reg [15:0] cnt_r [0:`ARSEQ_NCNT-1];
wire [3:0] st_d;
reg [3:0] st_d_r;
assign st_d = st_d_r;
wire [`ARSEQ_NCNT-1:0] cnt_inc;
assign cnt_inc[4:0] = (st_r == S_OPEN && st_d == S_READY) ?
  (5'h01 << prio_r) : 5'h00;
assign cnt_inc[5] = (st_r != S_RECLAIM) && (st_d == S_RECLAIM) && succ_r;
assign cnt_inc[6] = (st_r == S_FTRIP) && (st_d != S_FTRIP);
assign cnt_inc[7] = (st_r == S_LOCK) && (st_d != S_LOCK);
assign cnt_inc[8] = (st_r == S_HALT) && (st_d != S_HALT);
assign cnt_inc[9] = mclr & ~in_d_r[6];
wire apb_wr = psel & penable & pwrite;
wire cnt_clr_wr = apb_wr && (paddr == `ARSEQ_A_CNTCLR);
genvar g;
generate
  for (g = 0; g < `ARSEQ_NCNT; g = g + 1) begin : g_cnt
    always @(posedge pclk or negedge presetn) begin
      if (!presetn)
        cnt_r[g] <= 16'h0000;
      else if (cnt_inc[g])
        cnt_r[g] <= cnt_r[g] + 16'h0001;
      else if (cnt_clr_wr && pwdata[g])
        cnt_r[g] <= 16'h0000;
    end
  end
endgenerate
always @(posedge pclk or negedge presetn) begin
  if (!presetn)
    st_d_r <= S_OFF;
  else
    st_d_r <= st_r;
end
////////////////////////////////////////////////////////////////////////////
// APB slave: zero wait states, unmapped addresses answer pslverr
wire cnt_sel = (paddr >= `ARSEQ_A_CNT0) &&
  (paddr < `ARSEQ_A_CNT0 + 4 * `ARSEQ_NCNT);
wire [3:0] cnt_idx = paddr[5:2];
wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `ARSEQ_A_CNTCLR || cnt_sel);
assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ctrl_r <= `ARSEQ_CTRL_RST;
    dead_r <= 32'h0000_0000;
    reclaim_r <= 32'h0000_0000;
    action_r <= 32'h0000_0000;
    grcl_r <= 32'h0000_0000;
    evten_r <= 32'h00FF_FFFF;
  end else if (apb_wr) begin
    case (paddr)
      `ARSEQ_A_CTRL: ctrl_r <= pwdata;
      `ARSEQ_A_DEAD: dead_r <= pwdata;
      `ARSEQ_A_RECLAIM: reclaim_r <= pwdata;
      `ARSEQ_A_ACTION: action_r <= pwdata;
      `ARSEQ_A_GRECLAIM: grcl_r <= pwdata;
      `ARSEQ_A_EVTEN: evten_r <= pwdata;
      default: ;
    endcase
  end
end
always @* begin
  case (paddr)
    `ARSEQ_A_CTRL: prdata = ctrl_r;
    `ARSEQ_A_STATUS: prdata = {8'h00, shot_running, request_active,
      7'h00, shot_r, st_r};
    `ARSEQ_A_DEAD: prdata = dead_r;
    `ARSEQ_A_RECLAIM: prdata = reclaim_r;
    `ARSEQ_A_ACTION: prdata = action_r;
    `ARSEQ_A_GRECLAIM: prdata = grcl_r;
    `ARSEQ_A_EVTEN: prdata = evten_r;
    `ARSEQ_A_EVENT: prdata = {15'h0000, ev_v_r, 8'h00, ev_c_r};
    default: prdata = cnt_sel ? {16'h0000, cnt_r[cnt_idx]} : 32'h0000_0000;
  endcase
end
endmodule

/* File: arseq_regs.vh */
// Register map, field positions and timing constants of the recloser
`ifndef ARSEQ_REGS_VH
`define ARSEQ_REGS_VH
`define ARSEQ_CLK_HZ 40000000
`define ARSEQ_TICK_MS 1
`define ARSEQ_TICK_CYC (`ARSEQ_CLK_HZ / 1000 * `ARSEQ_TICK_MS)
`define ARSEQ_A_CTRL 12'h000
`define ARSEQ_A_STATUS 12'h004
`define ARSEQ_A_DEAD 12'h008
`define ARSEQ_A_RECLAIM 12'h00C
`define ARSEQ_A_ACTION 12'h010
`define ARSEQ_A_GRECLAIM 12'h014
`define ARSEQ_A_EVTEN 12'h018
`define ARSEQ_A_EVENT 12'h01C
`define ARSEQ_A_CNTCLR 12'h020
`define ARSEQ_A_CNT0 12'h040
`define ARSEQ_CTRL_ENABLE 0
`define ARSEQ_CTRL_USE_IN 1
`define ARSEQ_CTRL_USE_GRCL 2
`define ARSEQ_CTRL_SHOTS_LO 4
`define ARSEQ_CTRL_SHOTS_HI 6
`define ARSEQ_CTRL_MODE_LO 8
`define ARSEQ_CTRL_MODE_HI 12
`define ARSEQ_CTRL_RST 32'h0000_0015
`define ARSEQ_NCNT 10
`define ARSEQ_EVQ_DEPTH 8
`endif

/* File: arseq_breaker_model.sv */
// Behavioural circuit breaker standing behind the object control outputs
module arseq_brk_model #(
  parameter int DLY = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic open_cmd,
  input wire logic close_cmd,
  output logic open_status,
  output logic closed_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic closed_r;
  int cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // Mechanism travel takes DLY+1 cycles; a dropped command aborts the travel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_r <= 1'b1;
      cnt_r <= 0;
    end else if ((open_cmd && closed_r) || (close_cmd && !closed_r)) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == DLY) begin
        closed_r <= !closed_r;
        cnt_r <= 0;
      end
    end else begin
      cnt_r <= 0;
    end
  end
  // Never fails an operation, so object_fail stays low
  assign closed_status = closed_r;
  assign open_status = !closed_r;
endmodule

/* File: arseq_properties.sv */
// Concurrent checks on the recloser's top-level ports
module arseq_chk (
  input wire pclk,
  input wire presetn,
  input wire recloser_manual_clear,
  input wire critical_lockout_request,
  input wire breaker_open_status,
  input wire breaker_closed_status,
  input wire object_open_cmd,
  input wire object_close_cmd,
  input wire recloser_running,
  input wire recloser_locked,
  input wire recloser_ready,
  input wire [4:0] request_active,
  input wire [4:0] shot_running,
  input wire event_valid,
  input wire event_ready
);
  logic [3:0] clr_age_r;
  // Cycles since manual clear was last high, saturating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) clr_age_r <= 4'hF;
    else if (recloser_manual_clear) clr_age_r <= 4'h0;
    else if (clr_age_r != 4'hF) clr_age_r <= clr_age_r + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_close_met;
    object_close_cmd && breaker_closed_status;
  endsequence
  sequence s_open_met;
    object_open_cmd && breaker_open_status;
  endsequence
  chk_cmd_excl: assert property (
    !(object_open_cmd && object_close_cmd)) else $error("both commands high");
  chk_close_drop: assert property (
    s_close_met |-> ##[1:6] !object_close_cmd) else $error("close held");
  chk_open_drop: assert property (
    s_open_met |-> ##[1:6] !object_open_cmd) else $error("open held");
  chk_crit_lock: assert property (
    $rose(critical_lockout_request) |-> ##[1:10] recloser_locked)
    else $error("critical request did not lock");
  chk_lock_quiet: assert property (
    recloser_locked |-> !object_close_cmd) else $error("close while locked");
  chk_lock_release: assert property (
    $rose(recloser_ready) && $past(recloser_locked) |-> clr_age_r < 4'hC)
    else $error("left lock without manual clear");
  chk_ready_excl: assert property (
    recloser_ready |-> !recloser_locked && !recloser_running)
    else $error("ready together with locked or running");
  chk_one_shot: assert property (
    $onehot0(request_active) && $onehot0(shot_running))
    else $error("more than one request or shot active");
  chk_evt_hold: assert property (
    event_valid && !event_ready |=> event_valid) else $error("event lost");
endmodule

/* File: tb_auto_recloser_sequencer.sv */
// Self-checking bench for the recloser sequencer
module tb_auto_recloser_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [4:0] req = 5'h00;
  logic en_in = 1, clr = 0, lock = 0, crit = 0, ev_rdy = 1, err;
  logic mopen = 0, mclose = 0, ofail = 0;
  wire [31:0] prdata;
  wire [4:0] req_act;
  wire pready, pslverr, brk_open, brk_closed, open_cmd, close_cmd;
  wire r_on, r_lock, r_rdy, ev_valid;
  wire [5:0] mon = {ev_valid, r_on, r_lock, r_rdy, close_cmd, open_cmd};
  int bad_count = 0, tests_run = 0, n;
  always #12.5 pclk = ~pclk;
  arseq_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reclose_request_in(req), .recloser_enable_input(en_in),
    .recloser_manual_clear(clr), .recloser_lock_input(lock),
    .critical_lockout_request(crit), .breaker_open_status(brk_open),
    .breaker_closed_status(brk_closed), .manual_open_cmd(mopen),
    .manual_close_cmd(mclose), .object_fail(ofail),
    .object_open_cmd(open_cmd), .object_close_cmd(close_cmd),
    .recloser_on(r_on), .recloser_running(), .recloser_locked(r_lock),
    .recloser_ready(r_rdy), .dead_time_on(), .reclaim_time_on(),
    .arcing_time_on(), .final_trip_on(), .request_active(req_act),
    .shot_running(), .event_valid(ev_valid), .event_code(),
    .event_stamp(), .event_ready(ev_rdy));
  arseq_brk_model brk (.pclk(pclk), .presetn(presetn), .open_cmd(open_cmd),
    .close_cmd(close_cmd), .open_status(brk_open),
    .closed_status(brk_closed));
  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // Bounded wait on a monitored output, then compare it
  task waitv(input int i, input logic v);
    n = 0;
    while (mon[i] !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk_bit(mon[i], v);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse_clr;
    clr <= 1;
    repeat (10) @(posedge pclk);
    clr <= 0;
    waitv(2, 1);
  endtask
  // One full reclose; dead time must fall within dmin..dmax cycles
  task shot(input int dmin, input int dmax);
    req <= 5'b10001;
    waitv(0, 1);
    chk_word({27'h0, req_act}, 32'h1);
    waitv(0, 0);
    req <= 5'h00;
    n = 0;
    while (close_cmd !== 1'b1 && n < 90000) begin
      @(posedge pclk);
      n++;
    end
    chk_bit(n >= dmin && n <= dmax, 1'b1);
    waitv(1, 0);
    waitv(2, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    apb(0, 12'h000, 0);
    chk_word(rd, 32'h0000_0015);
    waitv(2, 1);
    chk_bit(open_cmd | close_cmd, 1'b0);
    apb(0, 12'h3FC, 0);
    chk_bit(err, 1'b1);
    apb(1, 12'h008, 0);
    apb(1, 12'h00C, 0);
    apb(1, 12'h010, 0);
    apb(1, 12'h014, 0);
    apb(1, 12'h000, 32'h0000_0011);
    shot(0, 60);
    apb(0, 12'h040, 0);
    chk_word(rd, 32'h0000_0001);
    apb(1, 12'h020, 32'h0000_0001);
    apb(0, 12'h040, 0);
    chk_word(rd, 32'h0000_0000);
    // Free-running ms tick: a 2 ms setting lands between 1 and 2 ms
    apb(1, 12'h008, 32'h0000_0002);
    shot(40000, 80100);
    apb(1, 12'h008, 0);
    ev_rdy <= 0;
    crit <= 1;
    waitv(3, 1);
    waitv(5, 1);
    chk_bit(open_cmd, 1'b0);
    repeat (4) @(posedge pclk);
    crit <= 0;
    ev_rdy <= 1;
    pulse_clr;
    lock <= 1;
    waitv(3, 1);
    lock <= 0;
    repeat (20) @(posedge pclk);
    chk_bit(r_lock, 1'b1);
    pulse_clr;
    apb(1, 12'h000, 32'h0000_0013);
    en_in <= 0;
    waitv(4, 0);
    en_in <= 1;
    waitv(4, 1);
    apb(1, 12'h000, 32'h0000_0011);
    en_in <= 0;
    repeat (10) @(posedge pclk);
    chk_bit(r_on, 1'b1);
    results;
  end
  initial begin
    #(95000 * 25);
    bad_count++;
    results;
  end
endmodule
bind arseq_top arseq_chk u_chk (.pclk(pclk), .presetn(presetn),
  .recloser_manual_clear(recloser_manual_clear),
  .critical_lockout_request(critical_lockout_request),
  .breaker_open_status(breaker_open_status),
  .breaker_closed_status(breaker_closed_status),
  .object_open_cmd(object_open_cmd), .object_close_cmd(object_close_cmd),
  .recloser_running(recloser_running), .recloser_locked(recloser_locked),
  .recloser_ready(recloser_ready), .request_active(request_active),
  .shot_running(shot_running), .event_valid(event_valid),
  .event_ready(event_ready));
